// ---- rtl/sap_sequencer.sv ----
`timescale 1ns/1ns
// serial port and conversion sequencer of the converter
module sap_sequencer import sap_pkg::*; #(
  parameter int BITS  = RESULT_BITS,
  parameter int DEPTH = FIFO_DEPTH
) (
  input  wire logic           REF_CLK,
  input  wire logic           RESETN,
  input  wire logic           CLK_EN,
  input  wire logic           CS_N,
  input  wire logic           SCLK,
  input  wire logic           DIN_I,
  output logic                DOUT_O,
  output logic                DOUT_OE_N,
  input  wire logic           COMP_I,
  output sap_analog_type      ANALOG,
  output logic [BITS-1:0]     TRIAL_CODE,
  output logic                BUSY,
  output logic                POWER_DOWN,
  output logic                OVERRUN,
  output logic                RES_VALID,
  output logic [BITS-1:0]     RES_DATA,
  input  wire logic           RES_READY
);

  // one-hot trial bit for the successive approximation
  function automatic logic [BITS-1:0] bit_mask(input logic [3:0] idx);
    bit_mask = BITS'(1) << idx;
  endfunction

  sap_state_type     state_q;
  sap_state_type     state_d;
  sap_analog_type    analog_q;
  sap_analog_type    analog_d;
  logic              sclk_prev_q;
  logic [2:0]        cfg_cnt_q;
  logic [2:0]        cfg_cnt_d;
  logic              sgl_q;
  logic              sgl_d;
  logic              odd_q;
  logic              odd_d;
  logic              msb_first_option_q;
  logic              msb_first_option_d;
  logic              shdn_q;
  logic              shdn_d;
  logic [3:0]        idx_q;
  logic [3:0]        idx_d;
  logic [1:0]        settle_q;
  logic [1:0]        settle_d;
  logic [BITS-1:0]   word_q;
  logic [BITS-1:0]   word_d;
  logic [BITS-1:0]   trial_q;
  logic [BITS-1:0]   trial_d;
  logic              dout_q;
  logic              dout_d;
  logic              oe_n_q;
  logic              oe_n_d;
  logic              busy_q;
  logic              busy_d;
  logic              pdown_q;
  logic              pdown_d;
  logic              ovr_q;
  logic              ovr_d;
  logic              push;
  logic              fifo_in_ready;
  logic              sclk_rise;
  logic              sclk_fall;

  // the converter clock is synchronous, so one flop finds its edges
  assign sclk_rise = SCLK & ~sclk_prev_q;
  assign sclk_fall = ~SCLK & sclk_prev_q;

  // next-state logic of the whole serial sequence
  always_comb begin
    state_d   = state_q;
    analog_d  = analog_q;
    cfg_cnt_d = cfg_cnt_q;
    sgl_d     = sgl_q;
    odd_d     = odd_q;
    msb_first_option_d    = msb_first_option_q;
    shdn_d    = shdn_q;
    idx_d     = idx_q;
    settle_d  = settle_q;
    word_d    = word_q;
    dout_d    = dout_q;
    oe_n_d    = oe_n_q;
    busy_d    = busy_q;
    pdown_d   = pdown_q;
    ovr_d     = ovr_q;
    push      = 1'b0;
    if (CS_N) begin
      // deselected: abandon the frame and free the shared line
      state_d  = ST_WAIT_START;
      analog_d = ANALOG_RESET;
      oe_n_d   = 1'b1;
      dout_d   = 1'b0;
      busy_d   = 1'b0;
      settle_d = 2'h0;
    end else begin
      unique case (state_q)
        ST_WAIT_START: begin
          // a high data bit on a rising edge is the start bit
          if (sclk_rise && DIN_I) begin
            state_d   = ST_CONFIG;
            cfg_cnt_d = CFG_SGL_IDX;
            pdown_d   = 1'b0;
            word_d    = '0;
          end
        end
        ST_CONFIG: begin
          // host owns the shared wire here, so no drive yet
          oe_n_d = 1'b1;
          if (sclk_rise && cfg_cnt_q != CFG_DONE_IDX) begin
            cfg_cnt_d = cfg_cnt_q + 3'h1;
            unique case (cfg_cnt_q)
              CFG_SGL_IDX: begin
                sgl_d = DIN_I;
              end
              CFG_ODD_IDX: begin
                // bit ahead of msb-first option opens sampling
                odd_d                   = DIN_I;
                analog_d.sample         = 1'b1;
                analog_d.pos_is_input_b = DIN_I;
                analog_d.neg_to_gnd     = sgl_q;
              end
              CFG_MSB_FIRST_OPTION_IDX: begin
                msb_first_option_d = DIN_I;
              end
              default: begin
                shdn_d = DIN_I;
              end
            endcase
          end else if (sclk_fall && cfg_cnt_q == CFG_DONE_IDX) begin
            // falling edge of the shutdown-option bit ends sampling
            analog_d.sample = 1'b0;
            if (shdn_q) begin
              analog_d.hold       = 1'b1;
              analog_d.cap_on_neg = 1'b1;
              state_d  = ST_CONVERT;
              idx_d    = MSB_IDX;
              settle_d = SETTLE_LOAD;
              busy_d   = 1'b1;
              oe_n_d   = 1'b0;
              dout_d   = 1'b0;
            end else begin
              pdown_d = 1'b1;
              state_d = ST_DONE;
            end
          end
        end
        ST_CONVERT: begin
          // let the comparator settle on the trial code, then decide
          if (settle_q != 2'h0) begin
            settle_d = settle_q - 2'h1;
            if (settle_q == 2'h1) begin
              word_d[idx_q] = COMP_I;
              if (msb_first_option_q) begin
                dout_d = COMP_I;
              end
            end
          end
          // one bit per converter clock, twelve in all
          if (sclk_fall && settle_q == 2'h0) begin
            if (idx_q == 4'h0) begin
              analog_d.hold       = 1'b0;
              analog_d.cap_on_neg = 1'b0;
              busy_d              = 1'b0;
              push                = 1'b1;
              ovr_d               = ovr_q | ~fifo_in_ready;
              if (msb_first_option_q) begin
                state_d = ST_DONE;
              end else begin
                state_d = ST_LSB_OUT;
                dout_d  = word_q[0];
                idx_d   = 4'h1;
              end
            end else begin
              idx_d    = idx_q - 4'h1;
              settle_d = SETTLE_LOAD;
            end
          end
        end
        ST_LSB_OUT: begin
          // without the option the word leaves lsb first afterwards
          if (sclk_fall) begin
            if (idx_q == MSB_IDX + 4'h1) begin
              state_d = ST_DONE;
              dout_d  = 1'b0;
            end else begin
              dout_d = word_q[idx_q];
              idx_d  = idx_q + 4'h1;
            end
          end
        end
        ST_DONE: begin
          dout_d = dout_q;
        end
      endcase
    end
    // the dac shows decided bits plus the bit under test
    trial_d = word_d | ((settle_d != 2'h0) ? bit_mask(idx_d) : '0);
  end

  // state registers, frozen while the clock enable is low
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      state_q     <= ST_WAIT_START;
      analog_q    <= ANALOG_RESET;
      sclk_prev_q <= 1'b0;
      cfg_cnt_q   <= 3'h0;
      sgl_q       <= 1'b0;
      odd_q       <= 1'b0;
      msb_first_option_q      <= 1'b0;
      shdn_q      <= 1'b0;
      idx_q       <= 4'h0;
      settle_q    <= 2'h0;
      word_q      <= '0;
      trial_q     <= '0;
      dout_q      <= 1'b0;
      oe_n_q      <= 1'b1;
      busy_q      <= 1'b0;
      pdown_q     <= 1'b0;
      ovr_q       <= 1'b0;
    end else if (CLK_EN) begin
      state_q     <= state_d;
      analog_q    <= analog_d;
      sclk_prev_q <= SCLK;
      cfg_cnt_q   <= cfg_cnt_d;
      sgl_q       <= sgl_d;
      odd_q       <= odd_d;
      msb_first_option_q      <= msb_first_option_d;
      shdn_q      <= shdn_d;
      idx_q       <= idx_d;
      settle_q    <= settle_d;
      word_q      <= word_d;
      trial_q     <= trial_d;
      dout_q      <= dout_d;
      oe_n_q      <= oe_n_d;
      busy_q      <= busy_d;
      pdown_q     <= pdown_d;
      ovr_q       <= ovr_d;
    end
  end

  // finished words queue for the on-chip reader; full drops and flags
  sap_fifo #(
    .WIDTH (BITS),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk       (REF_CLK),
    .resetn    (RESETN),
    .ce        (CLK_EN),
    .in_valid  (push),
    .in_ready  (fifo_in_ready),
    .in_data   (word_q),
    .out_valid (RES_VALID),
    .out_ready (RES_READY),
    .out_data  (RES_DATA)
  );

  assign DOUT_O     = dout_q;
  assign DOUT_OE_N  = oe_n_q;
  assign ANALOG     = analog_q;
  assign TRIAL_CODE = trial_q;
  assign BUSY       = busy_q;
  assign POWER_DOWN = pdown_q;
  assign OVERRUN    = ovr_q;

endmodule

// ---- pkg/sap_pkg.sv ----
package sap_pkg;

  // timing at the reference clock
  localparam int REF_CLK_PERIOD_NS = 10;
  localparam int COMP_SETTLE_NS    = 20;
  localparam int COMP_SETTLE_CYC   =
    (COMP_SETTLE_NS + REF_CLK_PERIOD_NS - 1) / REF_CLK_PERIOD_NS;
  localparam int LINK_CLK_MAX_KHZ  = 1000;

  // result and configuration layout
  localparam int RESULT_BITS   = 12;
  localparam int FIFO_DEPTH    = 4;
  localparam int CFG_BITS      = 4;
  localparam logic [2:0] CFG_SGL_IDX   = 3'h0;
  localparam logic [2:0] CFG_ODD_IDX   = 3'h1;
  localparam logic [2:0] CFG_MSB_FIRST_OPTION_IDX  = 3'h2;
  localparam logic [2:0] CFG_SHDN_IDX  = 3'h3;
  localparam logic [2:0] CFG_DONE_IDX  = 3'h4;
  localparam logic [3:0] MSB_IDX       = 4'hB;
  localparam logic [1:0] SETTLE_LOAD   = 2'(COMP_SETTLE_CYC);

  // converter sequence states
  typedef enum logic [4:0] {
    ST_WAIT_START = 5'h01,
    ST_CONFIG     = 5'h02,
    ST_CONVERT    = 5'h04,
    ST_LSB_OUT    = 5'h08,
    ST_DONE       = 5'h10
  } sap_state_type;

  // switches of the analog front end
  typedef struct packed {
    logic sample;        // capacitor tracks the plus input
    logic hold;          // plus input held
    logic cap_on_neg;    // capacitor switched to the minus input
    logic neg_to_gnd;    // minus side grounded internally
    logic pos_is_input_b; // plus side is analog_input_b
  } sap_analog_type;

  localparam sap_analog_type ANALOG_RESET = '0;

endpackage

// ---- rtl/sap_fifo.sv ----
`timescale 1ns/1ns
// shift-style queue so the head word sits in a flip-flop
module sap_fifo import sap_pkg::*; #(
  parameter int WIDTH = RESULT_BITS,
  parameter int DEPTH = FIFO_DEPTH
) (
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic             ce,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [WIDTH-1:0] mem_d [DEPTH];
  logic [DEPTH-1:0] vld_q;
  logic [DEPTH-1:0] vld_d;

  // honest full: no push into the last slot even while popping
  assign in_ready  = ~vld_q[DEPTH-1];
  assign out_valid = vld_q[0];
  assign out_data  = mem_q[0];

  // pop shifts down, push fills the lowest free slot
  always_comb begin
    logic pop;
    logic push;
    logic done;
    pop  = vld_q[0] & out_ready;
    push = in_valid & ~vld_q[DEPTH-1];
    done = 1'b0;
    for (int i = 0; i < DEPTH; i++) begin
      if (pop && i < DEPTH - 1) begin
        mem_d[i] = mem_q[i+1];
        vld_d[i] = vld_q[i+1];
      end else if (pop) begin
        mem_d[i] = mem_q[i];
        vld_d[i] = 1'b0;
      end else begin
        mem_d[i] = mem_q[i];
        vld_d[i] = vld_q[i];
      end
    end
    for (int i = 0; i < DEPTH; i++) begin
      if (push && !done && !vld_d[i]) begin
        mem_d[i] = in_data;
        vld_d[i] = 1'b1;
        done     = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      vld_q <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= '0;
      end
    end else if (ce) begin
      vld_q <= vld_d;
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= mem_d[i];
      end
    end
  end

endmodule

// ---- verification/sap_seq_chk_sva.sv ----
`timescale 1ns/1ns
// watches the converter ports for sequence slips
module sap_seq_chk import sap_pkg::*; #(
  parameter int BITS = RESULT_BITS
) (
  input wire logic            REF_CLK,
  input wire logic            RESETN,
  input wire logic            CS_N,
  input wire logic            SCLK,
  input wire logic            DOUT_OE_N,
  input wire sap_analog_type  ANALOG,
  input wire logic            BUSY,
  input wire logic            RES_VALID,
  input wire logic [BITS-1:0] RES_DATA,
  input wire logic            RES_READY
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RESETN);
  logic       sclk_q;
  logic [3:0] rise_q;
  logic [3:0] rise_d;
  logic [3:0] fall_q;
  logic [3:0] fall_d;
  // link edges seen inside the sample and hold phases
  always_comb begin
    rise_d = ANALOG.sample ? rise_q + 4'(SCLK & ~sclk_q) : 4'h0;
    fall_d = ANALOG.hold ? fall_q + 4'(~SCLK & sclk_q) : 4'h0;
  end
  // same single-flop edge finder as the port uses
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      sclk_q <= 1'b0;
      rise_q <= 4'h0;
      fall_q <= 4'h0;
    end else begin
      sclk_q <= SCLK;
      rise_q <= rise_d;
      fall_q <= fall_d;
    end
  end
  oe_off_cs_a: assert property (CS_N |=> DOUT_OE_N)
    else $error("data out driven while deselected");
  hold_cap_a: assert property (
    ANALOG.hold |-> ANALOG.cap_on_neg && !ANALOG.sample)
    else $error("hold without capacitor on minus input");
  busy_hold_a: assert property ($rose(BUSY) |-> $rose(ANALOG.hold))
    else $error("conversion began without hold");
  smp_len_a: assert property ($rose(ANALOG.hold) |-> rise_q == 4'h2)
    else $error("sample window not two and a half clocks");
  conv_len_a: assert property (
    $fell(ANALOG.hold) && !$past(CS_N) |-> fall_q == 4'hC)
    else $error("conversion not twelve link clocks");
  drive_cfg_a: assert property ($fell(DOUT_OE_N) |-> ANALOG.hold)
    else $error("data line driven during configuration");
  sel_only_a: assert property ($rose(ANALOG.sample) |-> !$past(CS_N))
    else $error("sampling started while deselected");
  fifo_hold_a: assert property (
    RES_VALID && !RES_READY |=> RES_VALID && $stable(RES_DATA))
    else $error("result word dropped before pop");
  cover property ($rose(ANALOG.hold));
  cover property ($fell(ANALOG.hold) && $past(CS_N));
  cover property (RES_VALID && RES_READY);
endmodule

bind sap_sequencer sap_seq_chk #(.BITS(BITS)) sap_seq_chk_i (
  .REF_CLK(REF_CLK), .RESETN(RESETN), .CS_N(CS_N), .SCLK(SCLK),
  .DOUT_OE_N(DOUT_OE_N), .ANALOG(ANALOG), .BUSY(BUSY),
  .RES_VALID(RES_VALID), .RES_DATA(RES_DATA), .RES_READY(RES_READY));

// ---- verification/sap_host.sv ----
`timescale 1ns/1ns
// host that bit-bangs select, link clock and the shared data wire
module sap_host #(
  parameter int HALF = 50 // 1 MHz link clock at 100 MHz
) (
  input  wire logic       clk,
  input  wire logic       go,
  input  wire logic       sel,
  input  wire logic [4:0] cfg,
  input  wire logic [4:0] nrd,
  input  wire logic       line,
  output logic            cs_n,
  output logic            sclk,
  output logic            drv,
  output logic            d,
  output logic [11:0]     word,
  output logic            done
);
  // one half period of the link clock
  task automatic half();
    repeat (HALF) @(negedge clk);
  endtask
  // config bits go out while clock is low, result read before each rise
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    drv = 1'b0;
    d = 1'b0;
    word = 12'h000;
    done = 1'b0;
    forever begin
      wait (go);
      @(negedge clk);
      cs_n = ~sel;
      drv = 1'b1;
      for (int i = 4; i >= 0; i--) begin
        d = cfg[i];
        half();
        sclk = 1'b1;
        half();
        sclk = 1'b0;
      end
      drv = 1'b0;
      // bits shift in from the right, so the first bit read ends on top
      for (int i = 0; i < nrd; i++) begin
        half();
        word = {word[10:0], line};
        sclk = 1'b1;
        half();
        sclk = 1'b0;
      end
      // the last fall must be seen while still selected, else it is lost
      half();
      cs_n = 1'b1;
      done = 1'b1;
      wait (!go);
      done = 1'b0;
    end
  end
endmodule

// ---- verification/tb_sap_sequencer.sv ----
`timescale 1ns/1ns
module tb_sap_sequencer import sap_pkg::*;;
  logic           ref_clk = 1'b0;
  logic           resetn = 1'b0;
  logic           go = 1'b0;
  logic           sel = 1'b1;
  logic           rdy = 1'b0;
  logic [4:0]     cfg = 5'h13;
  logic [4:0]     nrd = 5'h0C;
  logic [11:0]    vin = 12'h000;
  logic           cs_n, sclk, drv, d, done, line, dout, oe_n;
  logic           busy, pdn, ovr, rv;
  logic [11:0]    word, trial, rd;
  sap_analog_type ana;
  int             num_errors = 0;
  int             n_tests = 0;
  int             cyc = 0;
  always #5 ref_clk = ~ref_clk;
  // shared data wire with a pull-up when nobody drives it
  assign line = drv ? d : (oe_n ? 1'b1 : dout);
  // ideal comparator against the held input value
  sap_sequencer sap_sequencer_i (
    .REF_CLK(ref_clk), .RESETN(resetn), .CLK_EN(1'b1), .CS_N(cs_n),
    .SCLK(sclk), .DIN_I(line), .DOUT_O(dout), .DOUT_OE_N(oe_n),
    .COMP_I(trial <= vin), .ANALOG(ana), .TRIAL_CODE(trial), .BUSY(busy),
    .POWER_DOWN(pdn), .OVERRUN(ovr), .RES_VALID(rv), .RES_DATA(rd),
    .RES_READY(rdy));
  sap_host sap_host_i (
    .clk(ref_clk), .go(go), .sel(sel), .cfg(cfg), .nrd(nrd), .line(line),
    .cs_n(cs_n), .sclk(sclk), .drv(drv), .d(d), .word(word), .done(done));
  task automatic close_out();
    $display("checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(string nm, logic [11:0] exp, logic [11:0] got);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s exp %h got %h", nm, exp, got);
    end
  endtask
  // one host frame, waited for under a bound
  task automatic frame(logic [4:0] c, logic [4:0] n, logic [11:0] v);
    int k;
    cfg = c;
    nrd = n;
    vin = v;
    go = 1'b1;
    k = 0;
    while (!done && k < 4000) begin
      @(negedge ref_clk);
      k++;
    end
    chk("frame done", 12'h001, 12'(done));
    go = 1'b0;
    repeat (4) @(negedge ref_clk);
  endtask
  task automatic pop(logic [11:0] v);
    chk("res valid", 12'h001, 12'(rv));
    chk("res data", v, rd);
    rdy = 1'b1;
    @(negedge ref_clk);
    rdy = 1'b0;
    @(negedge ref_clk);
  endtask
  // every mux choice, fields looked at inside the sample window
  task automatic t_mux();
    logic [4:0]  c;
    logic [11:0] v;
    for (int i = 0; i < 4; i++) begin
      c = {1'b1, 2'(i), 2'b11};
      v = 12'h5A3 + 12'(i * 291);
      fork
        frame(c, 5'h0C, v);
        begin
          repeat (400) @(negedge ref_clk);
          chk("to ground", 12'(i >> 1), 12'(ana.neg_to_gnd));
          chk("plus b", 12'(i & 1), 12'(ana.pos_is_input_b));
          chk("sampling", 12'h001, 12'(ana.sample));
        end
      join
      chk("word", v, word);
      pop(v);
    end
  endtask
  // lsb-first readout follows the conversion on the same wire
  task automatic t_lsb();
    frame(5'h11, 5'h18, 12'h2C5);
    chk("lsb word", 12'hA34, word);
    pop(12'h2C5);
  endtask
  // traffic for another device on the shared bus
  task automatic t_other();
    sel = 1'b0;
    frame(5'h13, 5'h0C, 12'h123);
    sel = 1'b1;
    chk("analog idle", 12'h000, 12'(ana));
    chk("no word", 12'h000, 12'(rv));
  endtask
  // select dropped after three result bits
  task automatic t_abort();
    frame(5'h13, 5'h03, 12'h7FF);
    chk("oe after cs", 12'h001, 12'(oe_n));
    chk("no word", 12'h000, 12'(rv));
  endtask
  task automatic t_pdown();
    frame(5'h12, 5'h00, 12'h000);
    chk("power down", 12'h001, 12'(pdn));
    chk("no word", 12'h000, 12'(rv));
  endtask
  // five words into a four-deep queue, then drained
  task automatic t_fill();
    for (int i = 0; i < 5; i++)
      frame(5'h13, 5'h0C, 12'(i * 819 + 5));
    chk("pd cleared", 12'h000, 12'(pdn));
    chk("overrun", 12'h001, 12'(ovr));
    for (int i = 0; i < 4; i++)
      pop(12'(i * 819 + 5));
    chk("empty", 12'h000, 12'(rv));
  endtask
  initial begin
    repeat (12) @(negedge ref_clk);
    resetn = 1'b1;
    @(negedge ref_clk);
    t_mux();
    t_lsb();
    t_other();
    t_abort();
    t_pdown();
    t_fill();
    close_out();
  end
  // cut a hang short well past the expected run
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 40000) begin
      num_errors++;
      close_out();
    end
  end
endmodule
